// file: boot_serial_handshake.sv
// Boot serial handshake: mode detection from the first byte, clocked serial
// shifter with handshake pin, checksum accumulator and baud divider fields.
// Assumes the controller drives boot_serial_clock and serial_rx_line, and
// software on APB processes each byte and then writes the done bit.
//
// How it works
// - Checksum is two's complement of byte sum
// - Receive: enable receiver, raise handshake, shift
// - Byte received: handshake low until software done
// - Receive wait: last clock rise to handshake rise
// - Transmit: receiver off, load buffer, raise handshake
// - Byte sent: handshake low, then receiver back on at the software done write
// - Transmit wait: last clock rise to handshake rise
// - Handshake low wait after every byte
// - First byte timed as plain input edges
// - Clocked mode decided at point D, handshake up
// - Async mode leaves handshake undriven
// - Baud divider never faster than 02H
// - Prescale 5:4, divisor 3:0, fraction 3:0
// - AB not above CD means asynchronous mode
// - Clocked mode sends 30H as second byte
`timescale 1ns/1ps
module boot_serial_handshake
  import bsh_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        boot_serial_clock,
  input  wire logic        serial_rx_line,
  output logic             serial_tx_line,
  output logic             handshake_out,
  output logic             handshakeOe,
  output logic [1:0]       prescale_select,
  output logic [3:0]       baudDivisor,
  output logic [3:0]       baudFraction
);
  import bsh_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic sclkSync;
  logic rxSync;

  bsh_sync #(.RESET_VAL(1'b0)) u_sync_sclk (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .asyncIn  (boot_serial_clock),
    .syncOut  (sclkSync)
  );

  bsh_sync #(.RESET_VAL(1'b1)) u_sync_rx (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .asyncIn  (serial_rx_line),
    .syncOut  (rxSync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State
  bsh_mode_e                 mode_ff,      nxt_mode;
  logic [2:0]                edgeCnt_ff,   nxt_edgeCnt;
  logic [EDGE_TIMER_W-1:0]   timer_ff,     nxt_timer;
  logic [EDGE_TIMER_W-1:0]   tA_ff,        nxt_tA;
  logic [EDGE_TIMER_W-1:0]   tB_ff,        nxt_tB;
  logic [EDGE_TIMER_W-1:0]   tC_ff,        nxt_tC;
  logic                      sclkPrev_ff,  nxt_sclkPrev;
  logic                      rxPrev_ff,    nxt_rxPrev;
  logic                      hs_ff,        nxt_hs;
  logic                      hsOe_ff,      nxt_hsOe;
  logic                      rxEnable_ff,  nxt_rxEnable;
  logic                      txMode_ff,    nxt_txMode;
  logic [7:0]                shift_ff,     nxt_shift;
  logic [2:0]                bitCnt_ff,    nxt_bitCnt;
  logic                      rxDone_ff,    nxt_rxDone;
  logic                      txDone_ff,    nxt_txDone;
  logic                      txLine_ff,    nxt_txLine;
  logic [7:0]                rxData_ff,    nxt_rxData;
  logic [7:0]                txData_ff,    nxt_txData;
  logic [7:0]                baudDiv_ff,   nxt_baudDiv;
  logic [3:0]                baudFr_ff,    nxt_baudFr;
  logic [31:0]               prdata_ff,    nxt_prdata;
  logic                      pready_ff,    nxt_pready;
  logic                      pslverr_ff,   nxt_pslverr;

  logic       ckAdd;
  logic       ckClr;
  logic [7:0] ckValue;

  bsh_checksum #(.W(8)) u_cksum (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .addByte  (ckAdd),
    .dataByte (nxt_rxData),
    .clearSum (ckClr),
    .checksum (ckValue)
  );

  logic sclkRise;
  logic sclkFall;
  logic rxFall;
  logic rxRise;
  logic apbAcc;
  logic apbWr;
  logic [EDGE_TIMER_W-1:0] intervalAB;
  logic [EDGE_TIMER_W-1:0] intervalCD;

  assign sclkRise   = sclkSync & ~sclkPrev_ff;
  assign sclkFall   = ~sclkSync & sclkPrev_ff;
  assign rxFall     = ~rxSync & rxPrev_ff;
  assign rxRise     = rxSync & ~rxPrev_ff;
  assign apbAcc     = psel & penable & ~pready_ff;
  assign apbWr      = apbAcc & pwrite;
  assign intervalAB = tB_ff - tA_ff;
  assign intervalCD = timer_ff - tC_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Mode detection and handshake shifter
  always_comb begin
    nxt_mode     = mode_ff;
    nxt_edgeCnt  = edgeCnt_ff;
    nxt_timer    = timer_ff;
    nxt_tA       = tA_ff;
    nxt_tB       = tB_ff;
    nxt_tC       = tC_ff;
    nxt_sclkPrev = sclkSync;
    nxt_rxPrev   = rxSync;
    nxt_hs       = hs_ff;
    nxt_hsOe     = hsOe_ff;
    nxt_rxEnable = rxEnable_ff;
    nxt_txMode   = txMode_ff;
    nxt_shift    = shift_ff;
    nxt_bitCnt   = bitCnt_ff;
    nxt_rxDone   = rxDone_ff;
    nxt_txDone   = txDone_ff;
    nxt_txLine   = txLine_ff;
    nxt_rxData   = rxData_ff;
    ckAdd        = 1'b0;
    ckClr        = apbWr && paddr == ADDR_CTRL && pwdata[CTRL_CKCLR_POS];
    case (mode_ff)
      BSH_MODE_DETECT: begin
        // Saturating timer; a wrap would corrupt the interval compare
        if (timer_ff != '1) begin
          nxt_timer = timer_ff + 1'b1;
        end
        if (rxFall || rxRise) begin
          nxt_edgeCnt = edgeCnt_ff + 3'd1;
          case (edgeCnt_ff)
            3'd0: nxt_tA = timer_ff;
            3'd1: nxt_tB = timer_ff;
            3'd2: nxt_tC = timer_ff;
            3'd3: begin
              if (intervalAB > intervalCD) begin
                nxt_mode     = BSH_MODE_CLOCKED;
                nxt_hs       = 1'b1;
                nxt_hsOe     = 1'b1;
                nxt_txMode   = 1'b1;
                nxt_rxEnable = 1'b0;
                nxt_shift    = CLOCKED_REPLY;
                nxt_txLine   = CLOCKED_REPLY[7];
                nxt_bitCnt   = 3'd0;
              end else begin
                nxt_mode = BSH_MODE_ASYNC;
              end
            end
            default: nxt_edgeCnt = edgeCnt_ff;
          endcase
        end
      end
      BSH_MODE_ASYNC: begin
        nxt_hsOe = 1'b0;
        nxt_hs   = 1'b0;
      end
      BSH_MODE_CLOCKED: begin
        if (hs_ff && sclkFall && txMode_ff) begin
          nxt_txLine = shift_ff[7];
        end
        if (hs_ff && sclkRise) begin
          nxt_bitCnt = bitCnt_ff + 3'd1;
          if (txMode_ff) begin
            nxt_shift = {shift_ff[6:0], 1'b1};
          end else begin
            nxt_shift = {shift_ff[6:0], rxSync};
          end
          if (bitCnt_ff == 3'd7) begin
            nxt_hs = 1'b0;
            if (txMode_ff) begin
              nxt_txDone = 1'b1;
            end else begin
              nxt_rxDone = 1'b1;
              nxt_rxData = {shift_ff[6:0], rxSync};
              ckAdd      = 1'b1;
            end
          end
        end
        if (apbWr && paddr == ADDR_CTRL && !hs_ff) begin
          if (pwdata[CTRL_TXGO_POS]) begin
            nxt_rxDone   = 1'b0;
            nxt_txDone   = 1'b0;
            nxt_txMode   = 1'b1;
            nxt_rxEnable = 1'b0;
            nxt_shift    = txData_ff;
            nxt_txLine   = txData_ff[7];
            nxt_bitCnt   = 3'd0;
            nxt_hs       = 1'b1;
          end else if (pwdata[CTRL_DONE_POS]) begin
            nxt_rxDone   = 1'b0;
            nxt_txDone   = 1'b0;
            nxt_txMode   = 1'b0;
            nxt_rxEnable = 1'b1;
            nxt_bitCnt   = 3'd0;
            nxt_hs       = 1'b1;
          end
        end
      end
      default: nxt_mode = BSH_MODE_DETECT;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, registers
  always_comb begin
    nxt_pready  = apbAcc;
    nxt_pslverr = 1'b0;
    nxt_prdata  = prdata_ff;
    nxt_txData  = txData_ff;
    nxt_baudDiv = baudDiv_ff;
    nxt_baudFr  = baudFr_ff;
    if (apbAcc) begin
      nxt_prdata = '0;
      case (paddr)
        ADDR_CTRL:   nxt_prdata = 32'h0000_0000;
        ADDR_STATUS: nxt_prdata = {24'h00_0000, rxEnable_ff, txMode_ff, hs_ff,
                                   txDone_ff, rxDone_ff, 1'b0, mode_ff};
        ADDR_TXDATA: nxt_prdata = {24'h00_0000, txData_ff};
        ADDR_RXDATA: nxt_prdata = {24'h00_0000, rxData_ff};
        ADDR_BAUDDV: nxt_prdata = {24'h00_0000, baudDiv_ff};
        ADDR_BAUDFR: nxt_prdata = {28'h000_0000, baudFr_ff};
        ADDR_CKSUM:  nxt_prdata = {24'h00_0000, ckValue};
        default:     nxt_pslverr = 1'b1;
      endcase
      if (pwrite) begin
        case (paddr)
          ADDR_TXDATA: nxt_txData = pwdata[7:0];
          ADDR_BAUDDV: begin
            // Values faster than the limit are clamped, not stored
            if ({2'b00, pwdata[5:0]} < BAUD_DIV_MIN) begin
              nxt_baudDiv = BAUD_DIV_MIN;
            end else begin
              nxt_baudDiv = {2'b00, pwdata[5:0]};
            end
          end
          ADDR_BAUDFR: nxt_baudFr = pwdata[3:0];
          default:     nxt_baudFr = baudFr_ff;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_ff     <= BSH_MODE_DETECT;
      edgeCnt_ff  <= 3'd0;
      timer_ff    <= '0;
      tA_ff       <= '0;
      tB_ff       <= '0;
      tC_ff       <= '0;
      sclkPrev_ff <= 1'b0;
      rxPrev_ff   <= 1'b1;
      hs_ff       <= 1'b0;
      hsOe_ff     <= 1'b0;
      rxEnable_ff <= 1'b0;
      txMode_ff   <= 1'b0;
      shift_ff    <= 8'h00;
      bitCnt_ff   <= 3'd0;
      rxDone_ff   <= 1'b0;
      txDone_ff   <= 1'b0;
      txLine_ff   <= 1'b1;
      rxData_ff   <= 8'h00;
      txData_ff   <= 8'h00;
      baudDiv_ff  <= BAUD_DIV_RESET;
      baudFr_ff   <= BAUD_FR_RESET;
      prdata_ff   <= 32'h0000_0000;
      pready_ff   <= 1'b0;
      pslverr_ff  <= 1'b0;
    end else begin
      mode_ff     <= nxt_mode;
      edgeCnt_ff  <= nxt_edgeCnt;
      timer_ff    <= nxt_timer;
      tA_ff       <= nxt_tA;
      tB_ff       <= nxt_tB;
      tC_ff       <= nxt_tC;
      sclkPrev_ff <= nxt_sclkPrev;
      rxPrev_ff   <= nxt_rxPrev;
      hs_ff       <= nxt_hs;
      hsOe_ff     <= nxt_hsOe;
      rxEnable_ff <= nxt_rxEnable;
      txMode_ff   <= nxt_txMode;
      shift_ff    <= nxt_shift;
      bitCnt_ff   <= nxt_bitCnt;
      rxDone_ff   <= nxt_rxDone;
      txDone_ff   <= nxt_txDone;
      txLine_ff   <= nxt_txLine;
      rxData_ff   <= nxt_rxData;
      txData_ff   <= nxt_txData;
      baudDiv_ff  <= nxt_baudDiv;
      baudFr_ff   <= nxt_baudFr;
      prdata_ff   <= nxt_prdata;
      pready_ff   <= nxt_pready;
      pslverr_ff  <= nxt_pslverr;
    end
  end

  assign prdata          = prdata_ff;
  assign pready          = pready_ff;
  assign pslverr         = pslverr_ff;
  assign serial_tx_line  = txLine_ff;
  assign handshake_out   = hs_ff;
  assign handshakeOe     = hsOe_ff;
  assign prescale_select = baudDiv_ff[PRESCALE_HI:PRESCALE_LO];
  assign baudDivisor     = baudDiv_ff[DIVISOR_HI:DIVISOR_LO];
  assign baudFraction    = baudFr_ff;
endmodule

// file: boot_serial_handshake_tb.sv
// Self-checking bench: APB master, controller model, scenario list.
// Assumes the design answers every APB access within 50 cycles.
`timescale 1ns/1ps
module boot_serial_handshake_tb;
  import bsh_pkg::*;
  logic core_clk, reset_n, psel, penable, pwrite, sclk, rxLine, txLine, hs, hsOe, pready, pslverr;
  logic [7:0] paddr, q;
  logic [31:0] pwdata, prdata;
  logic [1:0] presc;
  logic [3:0] div, frac;
  int mismatches = 0;
  int checks = 0;
  boot_serial_handshake u_boot_serial_handshake (.core_clk(core_clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .boot_serial_clock(sclk),
    .serial_rx_line(rxLine), .serial_tx_line(txLine), .handshake_out(hs),
    .handshakeOe(hsOe), .prescale_select(presc), .baudDivisor(div), .baudFraction(frac));
  bsh_ctrl_model u_bsh_ctrl_model (.clk(core_clk), .sclk(sclk), .rxLine(rxLine),
    .txLine(txLine));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, r, exp);
  endtask
  task automatic waitHs(input logic lvl);
    int n;
    n = 0;
    while (hs !== lvl && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 3000) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  task automatic rst();
    reset_n <= 1'b0;
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
  endtask
  // Shift one byte once the handshake is high, then expect it low
  task automatic xferHs(input logic [7:0] d);
    waitHs(1'b1);
    u_bsh_ctrl_model.xfer(d, q);
    repeat (3) @(posedge core_clk);
    chk("hs after byte", {31'h0, hs}, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    rst();
    rdc("baud reset", ADDR_BAUDDV, 32'h02);
    rdc("frac reset", ADDR_BAUDFR, 32'h0);
    wr(ADDR_BAUDDV, 32'h3B);
    wr(ADDR_BAUDFR, 32'h0A);
    chk("baud pins", {22'h0, presc, div, frac}, 32'h3BA);
    wr(ADDR_BAUDDV, 32'h01);
    rdc("baud clamp", ADDR_BAUDDV, 32'h02);
    begin : unmapped
      logic [31:0] r;
      logic e;
      apb(1'b0, 8'h1C, 32'h0, r, e);
      chk("unmapped err", {31'h0, e}, 32'h1);
    end
    $display("test registers done");
    u_bsh_ctrl_model.modeByte(30, 40, 30);
    repeat (50) @(posedge core_clk);
    rdc("async mode", ADDR_STATUS, {30'h0, BSH_MODE_ASYNC});
    chk("async oe", {31'h0, hsOe}, 32'h0);
    $display("test async done");
    rst();
    u_bsh_ctrl_model.modeByte(40, 40, 20);
    repeat (8) @(posedge core_clk);
    chk("clocked hs", {30'h0, hsOe, hs}, 32'h3);
    xferHs(8'h00);
    chk("second byte", {24'h0, q}, 32'h30);
    rdc("tx done", ADDR_STATUS, 32'h52);
    wr(ADDR_CTRL, 32'h5);
    xferHs(8'hE5);
    rdc("rx byte", ADDR_RXDATA, 32'hE5);
    rdc("rx done", ADDR_STATUS, 32'h8A);
    repeat (8) u_bsh_ctrl_model.xfer(8'h11, q);
    rdc("edges ignored", ADDR_RXDATA, 32'hE5);
    chk("hs held low", {31'h0, hs}, 32'h0);
    wr(ADDR_CTRL, 32'h1);
    xferHs(8'hF6);
    rdc("checksum", ADDR_CKSUM, 32'h25);
    wr(ADDR_CTRL, 32'h4);
    rdc("checksum clear", ADDR_CKSUM, 32'h0);
    wr(ADDR_TXDATA, 32'hA5);
    wr(ADDR_CTRL, 32'h2);
    rdc("tx armed", ADDR_STATUS, 32'h62);
    xferHs(8'h00);
    chk("tx byte", {24'h0, q}, 32'hA5);
    wr(ADDR_CTRL, 32'h1);
    waitHs(1'b1);
    rdc("rx back on", ADDR_STATUS, 32'hA2);
    $display("test clocked done");
    report_and_stop();
  end
endmodule
bind boot_serial_handshake bsh_monitor u_bsh_monitor (.core_clk(core_clk), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .boot_serial_clock(boot_serial_clock),
  .serial_rx_line(serial_rx_line), .serial_tx_line(serial_tx_line),
  .handshake_out(handshake_out), .handshakeOe(handshakeOe),
  .prescale_select(prescale_select), .baudDivisor(baudDivisor), .baudFraction(baudFraction));

// file: bsh_checksum.sv
// Running checksum: byte sum modulo 256, read out as two's complement.
// Assumes add and clear pulses come from core_clk logic.
`timescale 1ns/1ps
module bsh_checksum #(
  parameter int unsigned W = 8
) (
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  input  wire logic         addByte,
  input  wire logic [W-1:0] dataByte,
  input  wire logic         clearSum,
  output logic [W-1:0]      checksum
);
  logic [W-1:0] sum_ff;
  logic [W-1:0] nxt_sum;

  always_comb begin
    nxt_sum = sum_ff;
    if (clearSum) begin
      nxt_sum = '0;
    end
    if (addByte) begin
      nxt_sum = (clearSum ? '0 : sum_ff) + dataByte;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sum_ff <= '0;
    end else begin
      sum_ff <= nxt_sum;
    end
  end

  assign checksum = W'(0) - sum_ff;
endmodule

// file: bsh_ctrl_model.sv
// Behavioural boot controller: mode byte edges and clocked byte shifts.
// Assumes the bench calls a shift after seeing the handshake rise, except the edges-ignored shifts.
`timescale 1ns/1ps
module bsh_ctrl_model (
  input  wire logic clk,
  output logic      sclk,
  output logic      rxLine,
  input  wire logic txLine
);
  initial begin
    sclk   = 1'b0;
    rxLine = 1'b1;
  end
  // Falls at A and C, rises at B and D; line stays high after D
  // Intervals are counted in core clock cycles
  task automatic modeByte(input int ab, input int bc, input int cd);
    @(posedge clk);
    rxLine <= 1'b0;
    repeat (ab) @(posedge clk);
    rxLine <= 1'b1;
    repeat (bc) @(posedge clk);
    rxLine <= 1'b0;
    repeat (cd) @(posedge clk);
    rxLine <= 1'b1;
  endtask
  // Five or six core cycles per phase, so the synchronised edges keep up
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk);
      rxLine <= d[i];
      repeat (5) @(posedge clk);
      sclk <= 1'b1;
      q[i] = txLine;
      repeat (5) @(posedge clk);
      sclk <= 1'b0;
    end
    @(posedge clk);
    rxLine <= 1'b1; // Released line returns to its idle high level
  endtask
endmodule

// file: bsh_monitor.sv
// Port checker for the boot serial handshake block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module bsh_monitor
  import bsh_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        boot_serial_clock,
  input wire logic        serial_rx_line,
  input wire logic        serial_tx_line,
  input wire logic        handshake_out,
  input wire logic        handshakeOe,
  input wire logic [1:0]  prescale_select,
  input wire logic [3:0]  baudDivisor,
  input wire logic [3:0]  baudFraction
);
  import bsh_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Cycles since the last raw clock rise and since the last completed CTRL write
  logic [7:0] sinceClk_ff, nxt_sinceClk, sinceWr_ff, nxt_sinceWr;
  logic       clkPrev_ff, nxt_clkPrev;
  always_comb begin
    nxt_clkPrev  = boot_serial_clock;
    nxt_sinceClk = (boot_serial_clock && !clkPrev_ff) ? 8'h00 :
                   (sinceClk_ff == 8'hFF) ? sinceClk_ff : sinceClk_ff + 8'h01;
    nxt_sinceWr  = (psel && penable && pready && pwrite && paddr == ADDR_CTRL) ? 8'h00 :
                   (sinceWr_ff == 8'hFF) ? sinceWr_ff : sinceWr_ff + 8'h01;
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      clkPrev_ff  <= 1'b0;
      sinceClk_ff <= 8'hFF;
      sinceWr_ff  <= 8'hFF;
    end else begin
      clkPrev_ff  <= nxt_clkPrev;
      sinceClk_ff <= nxt_sinceClk;
      sinceWr_ff  <= nxt_sinceWr;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing one cycle after access");
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_slverr_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_baud_floor: assert property ({prescale_select, baudDivisor} >= 6'(BAUD_DIV_MIN))
    else $error("baud divider below floor");
  // The design commits the write on the edge that raises pready, so the counter clears one edge later
  a_hs_rise_cause: assert property ($rose(handshake_out) && $past(handshakeOe)
                                    |-> ##[0:2] (sinceWr_ff == 8'h00))
    else $error("handshake rose without a done write");
  a_hs_fall_byte: assert property ($fell(handshake_out) |-> sinceClk_ff <= 8'd8)
    else $error("handshake fell without a clock rise");
  a_oe_sticky: assert property (handshakeOe |=> handshakeOe)
    else $error("handshake enable dropped");
  a_hs_needs_oe: assert property (handshake_out |-> handshakeOe)
    else $error("handshake high while undriven");
  a_tx_idle_high: assert property (!handshakeOe |-> serial_tx_line)
    else $error("tx line not idle outside clocked mode");
  c_err: cover property (pslverr);
  c_oe: cover property ($rose(handshakeOe));
  c_hs_back: cover property ($rose(handshake_out) && $past(handshakeOe));
endmodule

// file: bsh_pkg.sv
// Shared constants for the boot serial handshake block.
// Assumes a single 100 MHz core clock and an APB register bus.
package bsh_pkg;

  localparam int unsigned CLK_MHZ = 100;

  // APB register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TXDATA = 8'h08;
  localparam logic [7:0] ADDR_RXDATA = 8'h0C;
  localparam logic [7:0] ADDR_BAUDDV = 8'h10;
  localparam logic [7:0] ADDR_BAUDFR = 8'h14;
  localparam logic [7:0] ADDR_CKSUM  = 8'h18;

  // Control register bits
  localparam int unsigned CTRL_DONE_POS  = 0;
  localparam int unsigned CTRL_TXGO_POS  = 1;
  localparam int unsigned CTRL_CKCLR_POS = 2;

  // Baud divider fields
  localparam int unsigned PRESCALE_HI = 5;
  localparam int unsigned PRESCALE_LO = 4;
  localparam int unsigned DIVISOR_HI  = 3;
  localparam int unsigned DIVISOR_LO  = 0;
  localparam logic [7:0]  BAUD_DIV_MIN   = 8'h02;
  localparam logic [7:0]  BAUD_DIV_RESET = 8'h02;
  localparam logic [3:0]  BAUD_FR_RESET  = 4'h0;

  // Mode select
  localparam logic [7:0] CLOCKED_REPLY = 8'h30;
  localparam int unsigned EDGE_TIMER_W = 16;

  typedef enum logic [1:0] {BSH_MODE_DETECT, BSH_MODE_ASYNC, BSH_MODE_CLOCKED} bsh_mode_e;

endpackage

// file: bsh_sync.sv
// Two flip-flop synchroniser for one pin level.
// Assumes the input is asynchronous to core_clk.
`timescale 1ns/1ps
module bsh_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic asyncIn,
  output logic      syncOut
);
  logic stage1_ff;
  logic stage2_ff;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_ff <= RESET_VAL;
      stage2_ff <= RESET_VAL;
    end else begin
      stage1_ff <= asyncIn;
      stage2_ff <= stage1_ff;
    end
  end

  assign syncOut = stage2_ff;
endmodule
